// ===== status_pkg.sv
// How it works
// - event bits count only when enable bit set
// - bit 3 set by enabled device events
// - bit 4 follows output buffer holding data
// - bit 5 set by enabled standard events
// - master summary ORed into status bit 6
// - enable bit 6 always reads set
// - request flag set when summary rises
// - serial poll returns flag, clears flag only
// - other status bits survive serial poll
// - clear-status clears byte, flag, request line
// - clear-status keeps message bit while buffered
// - status query clears nothing
// - status byte zero when summaries zero
// - request enable cleared at power-up, zero mask
// - standard bit 0 after pending operations finish
// - standard bit 3 on device error
// - standard bit 4 on execution error
// - standard bit 5 on command error
// - standard bit 7 at power-up
// - standard events cleared: power-up, clear, query
// - standard enable cleared: power-up, zero mask
// - event bits latch until read; ignore writes
package status_pkg;

  // status byte field positions
  localparam int STB_DSB_POS = 3;  // device event summary
  localparam int STB_MAV_POS = 4;  // message available
  localparam int STB_ESB_POS = 5;  // standard event summary
  localparam int STB_MSS_POS = 6;  // master summary / request flag

  // standard event field positions
  localparam int ESR_OPC_POS = 0;  // operation complete
  localparam int ESR_DDE_POS = 3;  // device-dependent error
  localparam int ESR_EXE_POS = 4;  // execution error
  localparam int ESR_CME_POS = 5;  // command error
  localparam int ESR_PON_POS = 7;  // power on

  // register widths
  localparam int STB_W = 8;
  localparam int ESR_W = 8;
  localparam int DEV_W = 16;
  localparam int RESP_W = 16;

  // bits that may ever be one
  localparam logic [7:0]  STB_SUM_MASK  = 8'h38;
  localparam logic [7:0]  ESR_USED_MASK = 8'hB9;
  localparam logic [15:0] DEV_USED_MASK = 16'hFFF7;

  // values after reset
  localparam logic [7:0]  SRE_RESET  = 8'h00;
  localparam logic [15:0] RESP_RESET = 16'h0000;
  localparam logic [7:0]  POLL_RESET = 8'h00;

  // which register a query answers from
  typedef enum logic [2:0] {
    SRC_NONE,
    SRC_STB,
    SRC_SRE,
    SRC_ESR,
    SRC_ESE,
    SRC_DEV,
    SRC_DSE
  } resp_src_t;

endpackage : status_pkg

// ===== event_latch.sv
`timescale 1ns/1ns
// latched event register with its enable mask and summary
module event_latch
  import status_pkg::*;
#(
  parameter int          W    = 8,
  parameter logic [15:0] USED = 16'h00FF
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] set_bits,
  input  wire logic         clear,
  input  wire logic         mask_write,
  input  wire logic [W-1:0] mask_data,
  output logic      [W-1:0] event_q,
  output logic      [W-1:0] mask_q,
  output logic              summary
);

  // width check: logic is sized for at most 16 event bits
  if (W < 1 || W > 16) begin : g_bad_width
    $error("event_latch width must be 1 to 16");
  end

  typedef struct packed {
    logic [W-1:0] ev;  // latched events
    logic [W-1:0] en;  // enable mask
  } latch_t;

  latch_t cur_ff;
  latch_t nxt_cur;

  // set wins over a clear in the same cycle, so no event is lost
  always_comb begin
    nxt_cur = cur_ff;
    if (clear) begin
      nxt_cur.ev = '0;
    end
    nxt_cur.ev = (nxt_cur.ev | set_bits) & USED[W-1:0];
    if (mask_write) begin
      nxt_cur.en = mask_data;  // zero mask clears
    end
  end

  // power-up clears both registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign event_q = cur_ff.ev;
  assign mask_q  = cur_ff.en;
  assign summary = |(cur_ff.ev & cur_ff.en);

endmodule : event_latch

// ===== opc_tracker.sv
`timescale 1ns/1ns
// arms on the operation-complete command, fires once work drains
module opc_tracker (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic opc_cmd,
  input  wire logic cls_cmd,
  input  wire logic ops_pending,
  output logic      opc_done
);

  typedef struct packed {
    logic armed;  // waiting for pending work to finish
  } opc_t;

  opc_t cur_ff;
  opc_t nxt_cur;

  // clear-status drops a wait in progress; a new command re-arms
  always_comb begin
    nxt_cur = cur_ff;
    if (cur_ff.armed && !ops_pending) begin
      nxt_cur.armed = 1'b0;
    end
    if (cls_cmd) begin
      nxt_cur.armed = 1'b0;
    end
    if (opc_cmd) begin
      nxt_cur.armed = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // one-cycle pulse when the armed wait ends
  assign opc_done = cur_ff.armed && !ops_pending && !cls_cmd;

endmodule : opc_tracker

// ===== status_summary_service_request.sv
`timescale 1ns/1ns
// status byte, service request and the event register pair
// commands arrive as one-cycle strobes from the command parser
module status_summary_service_request
  import status_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  // mask-setting commands, mask already converted from decimal
  input  wire logic              sre_write,
  input  wire logic              ese_write,
  input  wire logic              dse_write,
  input  wire logic [DEV_W-1:0]  mask_data,
  // query commands
  input  wire logic              stb_query,
  input  wire logic              sre_query,
  input  wire logic              esr_query,
  input  wire logic              ese_query,
  input  wire logic              dev_query,
  input  wire logic              dse_query,
  // bus-level serial poll and clear-status
  input  wire logic              serial_poll,
  input  wire logic              cls_cmd,
  // operation-complete command and pending-work level
  input  wire logic              opc_cmd,
  input  wire logic              ops_pending,
  // error events from the parser and device
  input  wire logic              dev_error,
  input  wire logic              exec_error,
  input  wire logic              cmd_error,
  // device event set requests
  input  wire logic [DEV_W-1:0]  dev_events,
  // output buffer holds response data
  input  wire logic              out_buf_nonempty,
  // answers
  output logic      [RESP_W-1:0] resp_data,
  output logic                   resp_valid,
  output logic      [STB_W-1:0]  poll_data,
  output logic                   poll_valid,
  output logic                   srq,
  output logic      [STB_W-1:0]  status_byte
);

  // ----------------------------------------------------------------
  // own state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              pon_pending;  // power-on event still to log
    logic              rqs;          // request-service flag
    logic              mss_prev;     // summary one cycle ago
    logic [STB_W-1:0]  sre;          // service request mask
    logic [RESP_W-1:0] resp;         // query answer
    logic              resp_vld;     // answer strobe
    logic [STB_W-1:0]  poll;         // serial poll answer
    logic              poll_vld;     // poll answer strobe
  } top_t;

  top_t cur_ff;
  top_t nxt_cur;

  // ----------------------------------------------------------------
  // submodule wiring
  // ----------------------------------------------------------------
  logic [ESR_W-1:0] std_set;      // standard event set requests
  logic [ESR_W-1:0] std_event;    // latched standard events
  logic [ESR_W-1:0] std_mask;     // standard event mask
  logic             esb;          // standard event summary
  logic [DEV_W-1:0] dev_event;    // latched device events
  logic [DEV_W-1:0] dev_mask;     // device event mask
  logic             device_event_summary_bit;          // device event summary
  logic             opc_done;     // operation-complete pulse
  logic             std_clear;    // standard register clear
  logic             dev_clear;    // device register clear
  logic [STB_W-1:0] stb_now;      // live status byte, flag excluded
  logic             mss;          // master summary
  logic [STB_W-1:0] sre_view;     // mask as read back
  resp_src_t        src;          // selected query

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // assemble the status byte from its summaries; bit 6 is chosen by
  // the caller so query and poll share the same packing
  function automatic logic [STB_W-1:0] pack_stb(
    input logic d_sum,
    input logic m_av,
    input logic e_sum,
    input logic b6
  );
    logic [STB_W-1:0] r;
    r = '0;  // bits 0..2 and 7 stay zero
    r[STB_DSB_POS] = d_sum;
    r[STB_MAV_POS] = m_av;
    r[STB_ESB_POS] = e_sum;
    r[STB_MSS_POS] = b6;
    return r;
  endfunction : pack_stb

  // widen an 8-bit register to the answer width
  function automatic logic [RESP_W-1:0] widen(input logic [7:0] v);
    return {8'h00, v};
  endfunction : widen

  // ----------------------------------------------------------------
  // standard event sources
  // ----------------------------------------------------------------

  // each source sets its own bit; bits 1, 2, 6 never set
  always_comb begin
    std_set = '0;
    std_set[ESR_OPC_POS] = opc_done;
    std_set[ESR_DDE_POS] = dev_error;
    std_set[ESR_EXE_POS] = exec_error;
    std_set[ESR_CME_POS] = cmd_error;
    std_set[ESR_PON_POS] = cur_ff.pon_pending;
  end

  // an event register query empties the register read; clear-status empties both
  assign std_clear = esr_query | cls_cmd;
  assign dev_clear = dev_query | cls_cmd;

  opc_tracker u_opc (
    .clk         (clk),
    .resetn      (resetn),
    .opc_cmd     (opc_cmd),
    .cls_cmd     (cls_cmd),
    .ops_pending (ops_pending),
    .opc_done    (opc_done)
  );

  // masks come in already converted from the decimal argument;
  // the parser owns that conversion
  event_latch #(
    .W    (ESR_W),
    .USED ({8'h00, ESR_USED_MASK})
  ) u_std (
    .clk        (clk),
    .resetn     (resetn),
    .set_bits   (std_set),
    .clear      (std_clear),
    .mask_write (ese_write),
    .mask_data  (mask_data[ESR_W-1:0]),
    .event_q    (std_event),
    .mask_q     (std_mask),
    .summary    (esb)
  );

  // device event register: bit meanings belong to the device
  event_latch #(
    .W    (DEV_W),
    .USED (DEV_USED_MASK)
  ) u_dev (
    .clk        (clk),
    .resetn     (resetn),
    .set_bits   (dev_events),
    .clear      (dev_clear),
    .mask_write (dse_write),
    .mask_data  (mask_data),
    .event_q    (dev_event),
    .mask_q     (dev_mask),
    .summary    (device_event_summary_bit)
  );

  // ----------------------------------------------------------------
  // status byte and master summary
  // ----------------------------------------------------------------

  // summaries are live: once their sources drop, the byte reads zero;
  // message available tracks the buffer so clear-status cannot kill it
  assign stb_now = pack_stb(device_event_summary_bit, out_buf_nonempty, esb, 1'b0);

  // bit 6 of the mask is forced on in the read view only, the summary
  // itself never feeds back into the summary
  assign mss = |(stb_now & cur_ff.sre & STB_SUM_MASK);

  assign sre_view = cur_ff.sre | (STB_W'(1) << STB_MSS_POS);

  // pick one query per cycle; parser sends them one at a time, the
  // order here only settles an illegal overlap
  always_comb begin
    src = SRC_NONE;
    if (stb_query) begin
      src = SRC_STB;
    end else if (sre_query) begin
      src = SRC_SRE;
    end else if (esr_query) begin
      src = SRC_ESR;
    end else if (ese_query) begin
      src = SRC_ESE;
    end else if (dev_query) begin
      src = SRC_DEV;
    end else if (dse_query) begin
      src = SRC_DSE;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_cur          = cur_ff;
    nxt_cur.resp_vld = 1'b0;
    nxt_cur.poll_vld = 1'b0;
    nxt_cur.mss_prev = mss;

    // power-on event is logged once, on the first edge after reset
    nxt_cur.pon_pending = 1'b0;

    // mask write; a zero mask leaves everything disabled
    if (sre_write) begin
      nxt_cur.sre = mask_data[STB_W-1:0] & STB_SUM_MASK;
    end

    // query answers; the status query leaves every bit alone
    unique case (src)
      SRC_STB: begin
        nxt_cur.resp = widen(pack_stb(device_event_summary_bit, out_buf_nonempty, esb, mss));
      end
      SRC_SRE: begin
        nxt_cur.resp = widen(sre_view);
      end
      SRC_ESR: begin
        nxt_cur.resp = widen(std_event);
      end
      SRC_ESE: begin
        nxt_cur.resp = widen(std_mask);
      end
      SRC_DEV: begin
        nxt_cur.resp = dev_event;
      end
      SRC_DSE: begin
        nxt_cur.resp = dev_mask;
      end
      SRC_NONE: begin
        nxt_cur.resp = cur_ff.resp;  // hold last answer
      end
    endcase
    nxt_cur.resp_vld = (src != SRC_NONE);

    // serial poll: bits 3..5 live, bits 0..2 and 7 zero, request flag in bit 6
    if (serial_poll) begin
      nxt_cur.poll     = pack_stb(device_event_summary_bit, out_buf_nonempty, esb, cur_ff.rqs);
      nxt_cur.poll_vld = 1'b1;
      nxt_cur.rqs      = 1'b0;  // only the flag clears
    end

    // clear-status drops the flag and with it the request line; the
    // summaries fall on their own as the registers empty
    if (cls_cmd) begin
      nxt_cur.rqs = 1'b0;
    end

    // a fresh rise of the summary raises the request; it wins over a
    // poll or clear in the same cycle so the request is not lost
    if (mss && !cur_ff.mss_prev) begin
      nxt_cur.rqs = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------

  // power-up: all clear, power-on event armed
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cur_ff.pon_pending <= 1'b1;
      cur_ff.rqs         <= 1'b0;
      cur_ff.mss_prev    <= 1'b0;
      cur_ff.sre         <= SRE_RESET;
      cur_ff.resp        <= RESP_RESET;
      cur_ff.resp_vld    <= 1'b0;
      cur_ff.poll        <= POLL_RESET;
      cur_ff.poll_vld    <= 1'b0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign resp_data   = cur_ff.resp;
  assign resp_valid  = cur_ff.resp_vld;
  assign poll_data   = cur_ff.poll;
  assign poll_valid  = cur_ff.poll_vld;
  // request line follows the flag, so a poll or clear drops it
  assign srq         = cur_ff.rqs;
  // live view for a front panel; bit 6 shows the master summary
  assign status_byte = pack_stb(device_event_summary_bit, out_buf_nonempty, esb, mss);

endmodule : status_summary_service_request

// ===== status_sva.sv
`timescale 1ns/1ns
// watches the status outputs against the strobes that cause them
module status_sva
  import status_pkg::*;
(
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic              stb_query,
  input wire logic              esr_query,
  input wire logic              dev_query,
  input wire logic              serial_poll,
  input wire logic              cls_cmd,
  input wire logic              ops_pending,
  input wire logic              dev_error,
  input wire logic              exec_error,
  input wire logic              cmd_error,
  input wire logic [DEV_W-1:0]  dev_events,
  input wire logic              out_buf_nonempty,
  input wire logic [RESP_W-1:0] resp_data,
  input wire logic              resp_valid,
  input wire logic [STB_W-1:0]  poll_data,
  input wire logic              poll_valid,
  input wire logic [STB_W-1:0]  status_byte,
  input wire logic              srq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // no standard event can be set this cycle; pending work also blocks a late completion
  logic quiet;
  assign quiet = !dev_error && !exec_error && !cmd_error && ops_pending;
  // a poll answers next cycle with the flag dropped
  sequence s_poll_ans;
    ##1 poll_valid && !srq;
  endsequence
  sequence s_cls_done;
    ##1 !srq && status_byte[5:3] == {1'b0, out_buf_nonempty, 1'b0};
  endsequence
  property p_poll;
    serial_poll && !status_byte[6] |-> s_poll_ans;
  endproperty
  property p_poll_data;
    serial_poll |=> poll_data[5:0] == $past(status_byte[5:0]) && !poll_data[7]
                    && poll_data[6] == $past(srq);
  endproperty
  property p_srq_rise;
    $rose(status_byte[6]) |=> srq;
  endproperty
  property p_srq_hold;
    srq && !serial_poll && !cls_cmd |=> srq;
  endproperty
  // event set wins over clear, so only a quiet clear is judged
  property p_cls;
    cls_cmd && quiet && dev_events == 16'h0000 && !$rose(status_byte[6]) |-> s_cls_done;
  endproperty
  property p_esr_rd;
    esr_query && quiet |=> resp_valid && !status_byte[5];
  endproperty
  property p_dev_rd;
    dev_query && dev_events == 16'h0000 |=> !status_byte[3];
  endproperty
  property p_mav;
    status_byte[4] == out_buf_nonempty;
  endproperty
  property p_unused;
    status_byte[2:0] == 3'b000 && !status_byte[7];
  endproperty
  property p_stb_rd;
    stb_query |=> resp_valid && resp_data == {8'h00, $past(status_byte)};
  endproperty
  a_poll: assert property (p_poll) else $error("poll answer late or flag kept");
  a_poll_data: assert property (p_poll_data) else $error("poll byte wrong");
  a_srq_rise: assert property (p_srq_rise) else $error("no request on summary rise");
  a_srq_hold: assert property (p_srq_hold) else $error("request dropped alone");
  a_cls: assert property (p_cls) else $error("clear status incomplete");
  a_esr_rd: assert property (p_esr_rd) else $error("event summary kept after read");
  a_dev_rd: assert property (p_dev_rd) else $error("device summary kept after read");
  a_mav: assert property (p_mav) else $error("message bit off buffer");
  a_unused: assert property (p_unused) else $error("unused status bit set");
  a_stb_rd: assert property (p_stb_rd) else $error("status query wrong");
endmodule : status_sva

bind status_summary_service_request status_sva u_sva (
  .clk(clk), .resetn(resetn), .stb_query(stb_query), .esr_query(esr_query),
  .dev_query(dev_query), .serial_poll(serial_poll), .cls_cmd(cls_cmd),
  .ops_pending(ops_pending), .dev_error(dev_error), .exec_error(exec_error),
  .cmd_error(cmd_error), .dev_events(dev_events), .out_buf_nonempty(out_buf_nonempty),
  .resp_data(resp_data), .resp_valid(resp_valid), .poll_data(poll_data),
  .poll_valid(poll_valid), .status_byte(status_byte), .srq(srq)
);

// ===== ctl_model.sv
`timescale 1ns/1ns
// remote controller: issues one command strobe per call
module ctl_model (
  input  wire logic        clk,
  output logic             sre_write,
  output logic             ese_write,
  output logic             dse_write,
  output logic             stb_query,
  output logic             sre_query,
  output logic             esr_query,
  output logic             ese_query,
  output logic             dev_query,
  output logic             dse_query,
  output logic             serial_poll,
  output logic             cls_cmd,
  output logic             opc_cmd,
  output logic      [15:0] mask_data
);
  logic [11:0] cmd;  // one-hot strobe vector
  assign {sre_write, ese_write, dse_write, stb_query, sre_query, esr_query, ese_query,
          dev_query, dse_query, serial_poll, cls_cmd, opc_cmd} = cmd;
  initial begin
    cmd = 12'h000;
    mask_data = 16'h0000;
  end
  // strobe held across one rising edge; mask is the decimal value already converted
  task automatic issue(input int k, input logic [15:0] m);
    @(negedge clk);
    cmd = 12'h001 << k;
    mask_data = m;
    @(negedge clk);
    cmd = 12'h000;
    mask_data = ~m;  // released data must not look valid
  endtask : issue
endmodule : ctl_model

// ===== testbench.sv
`timescale 1ns/1ns
// self-checking bench for the status byte and service request
module testbench;
  import status_pkg::*;
  localparam int SREW = 11, ESEW = 10, DSEW = 9, STBQ = 8, SREQ = 7, ESRQ = 6;
  localparam int ESEQ = 5, DEVQ = 4, DSEQ = 3, POLL = 2, CLS = 1, OPC = 0;
  logic        clk, resetn, dev_error, exec_error, cmd_error, out_buf_nonempty, ops_pending;
  logic [15:0] dev_events;
  wire logic   sre_write, ese_write, dse_write, stb_query, sre_query, esr_query;
  wire logic   ese_query, dev_query, dse_query, serial_poll, cls_cmd, opc_cmd;
  wire logic [15:0] mask_data, resp_data;
  wire logic [7:0]  poll_data, status_byte;
  wire logic        resp_valid, poll_valid, srq;
  int          fail_count, cmp_count;
  logic [7:0]  tbl [3] = '{8'h20, 8'h10, 8'h08};  // cmd, exec, device error bits

  ctl_model ctl (.clk(clk), .sre_write(sre_write), .ese_write(ese_write),
    .dse_write(dse_write), .stb_query(stb_query), .sre_query(sre_query),
    .esr_query(esr_query), .ese_query(ese_query), .dev_query(dev_query),
    .dse_query(dse_query), .serial_poll(serial_poll), .cls_cmd(cls_cmd),
    .opc_cmd(opc_cmd), .mask_data(mask_data));
  status_summary_service_request dut (.clk(clk), .resetn(resetn), .sre_write(sre_write),
    .ese_write(ese_write), .dse_write(dse_write), .mask_data(mask_data),
    .stb_query(stb_query), .sre_query(sre_query), .esr_query(esr_query),
    .ese_query(ese_query), .dev_query(dev_query), .dse_query(dse_query),
    .serial_poll(serial_poll), .cls_cmd(cls_cmd), .opc_cmd(opc_cmd),
    .ops_pending(ops_pending), .dev_error(dev_error), .exec_error(exec_error),
    .cmd_error(cmd_error), .dev_events(dev_events), .out_buf_nonempty(out_buf_nonempty),
    .resp_data(resp_data), .resp_valid(resp_valid), .poll_data(poll_data),
    .poll_valid(poll_valid), .srq(srq), .status_byte(status_byte));

  always #5 clk = ~clk;
  // single compare: four-state inequality so unknowns never match
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // query and judge the answer in the cycle after the strobe edge
  task automatic rd(input int k, input logic [15:0] exp, input string nm);
    ctl.issue(k, 16'h0000);
    chk(nm, exp, (resp_valid === 1'b1) ? resp_data : 16'hxxxx);
  endtask : rd
  // one-cycle error and device event pulses
  task automatic ev(input logic [2:0] e, input logic [15:0] v);
    @(negedge clk);
    {dev_error, exec_error, cmd_error} = e;
    dev_events = v;
    @(negedge clk);
    {dev_error, exec_error, cmd_error} = 3'b000;
    dev_events = 16'h0000;
    @(negedge clk);  // request flag lands one edge after the summary
  endtask : ev
  task automatic t_power;
    rd(ESRQ, 16'h0080, "esr power on");
    rd(ESRQ, 16'h0000, "esr after read");
    rd(SREQ, 16'h0040, "sre reset");
    rd(ESEQ, 16'h0000, "ese reset");
    ctl.issue(POLL, 16'h0000);
    chk("poll idle", 16'h0000, 16'(poll_data));
    chk("poll valid", 16'h0001, 16'(poll_valid));
  endtask : t_power
  task automatic t_srq;
    ctl.issue(ESEW, 16'd8);
    ctl.issue(SREW, 16'd32);
    ev(3'b100, 16'h0000);
    chk("stb", 16'h0060, 16'(status_byte));
    chk("srq", 16'h0001, 16'(srq));
    rd(STBQ, 16'h0060, "stb query");
    chk("srq after query", 16'h0001, 16'(srq));
    ctl.issue(POLL, 16'h0000);
    chk("poll", 16'h0060, 16'(poll_data));
    chk("srq after poll", 16'h0000, 16'(srq));
    chk("stb after poll", 16'h0060, 16'(status_byte));
    rd(ESRQ, 16'h0008, "esr");
    chk("stb after read", 16'h0000, 16'(status_byte));
  endtask : t_srq
  task automatic t_codes;
    ctl.issue(ESEW, 16'd255);
    for (int i = 0; i < 3; i++) begin
      ev(3'b001 << i, 16'h0000);
      rd(ESRQ, 16'(tbl[i]), "esr code");
    end
  endtask : t_codes
  task automatic t_dev;
    ctl.issue(DSEW, 16'd32768);
    rd(DSEQ, 16'h8000, "dse");
    ev(3'b000, 16'h0009);
    chk("dsb masked", 16'h0000, 16'(status_byte & 8'h08));
    rd(DEVQ, 16'h0001, "dev");
    ev(3'b000, 16'h8000);
    chk("dsb", 16'h0008, 16'(status_byte & 8'h08));
    rd(DEVQ, 16'h8000, "dev");
    chk("dsb read", 16'h0000, 16'(status_byte & 8'h08));
  endtask : t_dev
  task automatic t_cls;
    out_buf_nonempty = 1'b1;
    ctl.issue(SREW, 16'd56);
    rd(SREQ, 16'h0078, "sre bit6");
    ev(3'b100, 16'h8000);
    chk("srq", 16'h0001, 16'(srq));
    ctl.issue(CLS, 16'h0000);
    chk("srq cls", 16'h0000, 16'(srq));
    chk("stb cls", 16'h0010, 16'(status_byte & 8'h38));
    rd(ESRQ, 16'h0000, "esr cls");
    out_buf_nonempty = 1'b0;
    @(negedge clk);
    chk("mav", 16'h0000, 16'(status_byte));
    ctl.issue(SREW, 16'd0);
    rd(SREQ, 16'h0040, "sre zero");
    ctl.issue(ESEW, 16'd0);
    rd(ESEQ, 16'h0000, "ese zero");
  endtask : t_cls
  task automatic t_opc;
    ctl.issue(OPC, 16'h0000);
    repeat (3) @(negedge clk);
    rd(ESRQ, 16'h0000, "opc busy");
    ops_pending = 1'b0;
    repeat (2) @(negedge clk);
    ops_pending = 1'b1;
    rd(ESRQ, 16'h0001, "opc done");
  endtask : t_opc
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  // watchdog: whole run is about a hundred cycles
  initial begin
    #50000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    {clk, resetn, dev_error, exec_error, cmd_error, out_buf_nonempty} = 6'b000000;
    ops_pending = 1'b1;  // held busy so a stray completion cannot set events
    dev_events = 16'h0000;
    repeat (16) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    t_power();
    t_srq();
    t_codes();
    t_dev();
    t_cls();
    t_opc();
    report_and_stop();
  end
endmodule : testbench
